/* File: include/wdac_pkg.sv */
// types shared by the watchdog, alarm and interrupt block
// no assumptions beyond the register header
package wdac_pkg;
    typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} wdac_bus_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] reload;
        logic [15:0] count;
        logic [7:0] alm_min;
        logic [7:0] alm_hr;
        logic [7:0] alm_day;
        logic wd_flag;
        logic al_flag;
        wdac_bus_t phase;
        logic [3:0] addr_q;
        logic [7:0] wdata_q;
        logic [7:0] rdata;
        logic rd_oe;
    } wdac_state_t;
endpackage

/* File: include/wdac_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a 4-bit register address
//
// Summary of operation
// RULE_01 - two BCD bytes hold 00.01 to 99.99 seconds
// RULE_02 - reload access restarts count, clears flag, pin
// RULE_03 - count down per tick, interrupt at zero
// RULE_04 - without access the alarm repeats each period
// RULE_05 - reload registers read back the entered value
// RULE_06 - both reload bytes zero disables watchdog
// RULE_07 - alarm mask bits select alarm rate
// RULE_08 - host uses only the four mask patterns
// RULE_09 - transfer_enable low freezes host time registers
// RULE_10 - interrupt_pin_swap routes alarms to pins
// RULE_11 - host never enables first pin and square wave
// RULE_12 - polarity bit selects source or sink, pin two
// RULE_13 - pulse mode asserts at least 3ms, then releases; a reload or alarm access ends the pulse at once
// RULE_14 - watchdog_irq_mask holds watchdog output inactive
// RULE_15 - alarm mask bit holds alarm output inactive
// RULE_16 - watchdog_flag read only, set on expiry
// RULE_17 - alarm_flag read only, cleared by alarm access
// RULE_18 - pulse mode flags read one only during pulse
// RULE_19 - time registers refreshed every hundredth second
// RULE_20 - bit 7 of alarm registers is mask bit
// RULE_21 - writes to flag bit positions are ignored
// RULE_22 - decrement once per tick, halt when disabled
`ifndef WDAC_REGS_SVH
`define WDAC_REGS_SVH

`define WDAC_ADDR_W 4
`define WDAC_OFS_ALM_MIN 4'h3
`define WDAC_OFS_ALM_HR 4'h5
`define WDAC_OFS_ALM_DAY 4'h7
`define WDAC_OFS_CMD 4'hB
`define WDAC_OFS_WD_LO 4'hC
`define WDAC_OFS_WD_HI 4'hD

`define WDAC_CMD_XFER 7
`define WDAC_CMD_SWAP 6
`define WDAC_CMD_POL 5
`define WDAC_CMD_PULSE 4
`define WDAC_CMD_WDMASK 3
`define WDAC_CMD_ALMASK 2
`define WDAC_CMD_WDFLAG 1
`define WDAC_CMD_ALFLAG 0
`define WDAC_ALM_MASK 7
`define WDAC_DAY_RO 8'h78

`define WDAC_CMD_RESET 8'h8C
`define WDAC_RELOAD_RESET 16'h0000

`define WDAC_CLK_KHZ 10000
`define WDAC_TICK_MS 10
`define WDAC_PULSE_MS 3
`define WDAC_TICK_CYCLES (`WDAC_TICK_MS * `WDAC_CLK_KHZ)
`define WDAC_PULSE_CYCLES (`WDAC_PULSE_MS * `WDAC_CLK_KHZ)
`define WDAC_CNT_W 17

`endif

/* File: logic/wdac_pulse.sv */
// interrupt pulse stretcher: active for CYCLES clocks after a start
// clear ends the pulse at once; start wins over clear
`timescale 1ns/1ns
`default_nettype none
`include "wdac_regs.svh"
module wdac_pulse #(
    parameter int CYCLES = `WDAC_PULSE_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic clear_in,
    output logic active_out
);
    typedef struct packed {
        logic [`WDAC_CNT_W-1:0] left;
    } wdac_pulse_st_t;

    wdac_pulse_st_t s;
    wdac_pulse_st_t next_s;

    always_comb
    begin
        next_s = s;
        if (start_in)
            next_s.left = `WDAC_CNT_W'(CYCLES);
        else if (clear_in)
            next_s.left = '0;
        else if (s.left != '0)
            next_s.left = s.left - `WDAC_CNT_W'(1);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign active_out = (s.left != '0);
endmodule // wdac_pulse
`default_nettype wire

/* File: logic/wdac_tick.sv */
// hundredth-second timebase: one-cycle enable every CYCLES clocks
// assumes a single free-running system clock
`timescale 1ns/1ns
`default_nettype none
`include "wdac_regs.svh"
module wdac_tick #(
    parameter int CYCLES = `WDAC_TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    typedef struct packed {
        logic [`WDAC_CNT_W-1:0] cnt;
        logic tick;
    } wdac_tick_st_t;

    wdac_tick_st_t s;
    wdac_tick_st_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == `WDAC_CNT_W'(CYCLES - 1))
        begin
            next_s.cnt = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt = s.cnt + `WDAC_CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick_out = s.tick;
endmodule // wdac_tick
`default_nettype wire

/* File: logic/wdac_top.sv */
// watchdog countdown, time-of-day alarm match and interrupt control
// bus pins are sampled synchronously to mclk_in; time-of-day chain is
// outside and supplies current BCD time and a minute rollover pulse
`timescale 1ns/1ns
`default_nettype none
`include "wdac_regs.svh"
module wdac_top #(
    parameter int TICK_CYCLES = `WDAC_TICK_CYCLES,
    parameter int PULSE_CYCLES = `WDAC_PULSE_CYCLES
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [`WDAC_ADDR_W-1:0] addr_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    input wire logic [7:0] cur_minutes_in,
    input wire logic [7:0] cur_hours_in,
    input wire logic [7:0] cur_days_in,
    input wire logic minute_rollover_in,
    output logic transfer_strobe_out,
    output logic first_interrupt_pin_out,
    output logic first_interrupt_pin_oe_out,
    output logic second_interrupt_pin_out,
    output logic second_interrupt_pin_oe_out
);
    wdac_pkg::wdac_state_t s;
    wdac_pkg::wdac_state_t next_s;
    wdac_pkg::wdac_bus_t phase_now;
    logic tick;
    logic acc_start;
    logic wr_end;
    logic wd_touch;
    logic al_touch;
    logic wd_expire;
    logic al_event;
    logic wd_act;
    logic al_act;
    logic [1:0] p_start;
    logic [1:0] p_clear;
    logic [1:0] p_active;

    function automatic logic is_wd(input logic [`WDAC_ADDR_W-1:0] a);
        is_wd = (a == `WDAC_OFS_WD_LO) || (a == `WDAC_OFS_WD_HI);
    endfunction

    function automatic logic is_alm(input logic [`WDAC_ADDR_W-1:0] a);
        is_alm = (a == `WDAC_OFS_ALM_MIN) || (a == `WDAC_OFS_ALM_HR) ||
                 (a == `WDAC_OFS_ALM_DAY);
    endfunction

    function automatic logic is_mine(input logic [`WDAC_ADDR_W-1:0] a);
        is_mine = is_wd(a) || is_alm(a) || (a == `WDAC_OFS_CMD);
    endfunction

    // four-digit bcd decrement
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (borrow)
            begin
                if (r[i*4 +: 4] == 4'h0)
                    r[i*4 +: 4] = 4'h9;
                else
                begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        bcd_dec = r;
    endfunction

    wdac_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // index 0 watchdog, index 1 time-of-day alarm
    assign p_start = {al_event, wd_expire};
    assign p_clear = {al_touch, wd_touch};

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_pulse
            wdac_pulse #(.CYCLES(PULSE_CYCLES)) u_pulse (
                .mclk_in(mclk_in),
                .rst_n_in(rst_n_in),
                .start_in(p_start[g]),
                .clear_in(p_clear[g]),
                .active_out(p_active[g])
            );
        end
    endgenerate

    always_comb
    begin
        if (!ce_n_in && !we_n_in)
            phase_now = wdac_pkg::BUS_WRITE;
        else if (!ce_n_in && !oe_n_in)
            phase_now = wdac_pkg::BUS_READ;
        else
            phase_now = wdac_pkg::BUS_IDLE;
    end

    assign acc_start = (phase_now != wdac_pkg::BUS_IDLE) &&
                       (phase_now != s.phase);
    assign wr_end = (s.phase == wdac_pkg::BUS_WRITE) &&
                    (phase_now != wdac_pkg::BUS_WRITE);
    assign wd_touch = (acc_start && is_wd(addr_in)) ||
                      (wr_end && is_wd(s.addr_q)); // RULE_02
    assign al_touch = (acc_start && is_alm(addr_in)) ||
                      (wr_end && is_alm(s.addr_q)); // RULE_17

    // expiry when the count would reach zero; all-zero reload halts
    // an access in the same cycle restarts but does not hide the event
    assign wd_expire = tick && (s.reload != 16'h0000) &&
                       (s.count <= 16'h0001); // RULE_03 RULE_06 RULE_22

    // mask bit set leaves that field out of the compare
    assign al_event = minute_rollover_in &&
        (s.alm_min[`WDAC_ALM_MASK] ||
         s.alm_min[6:0] == cur_minutes_in[6:0]) &&
        (s.alm_hr[`WDAC_ALM_MASK] ||
         s.alm_hr[6:0] == cur_hours_in[6:0]) &&
        (s.alm_day[`WDAC_ALM_MASK] ||
         s.alm_day[2:0] == cur_days_in[2:0]); // RULE_07 RULE_20

    always_comb
    begin
        next_s = s;
        next_s.phase = phase_now;
        if (phase_now == wdac_pkg::BUS_WRITE)
        begin
            next_s.addr_q = addr_in;
            next_s.wdata_q = dq_in;
        end
        // write commits at the trailing edge of the strobe
        if (wr_end)
        begin
            case (s.addr_q)
                `WDAC_OFS_CMD:
                    next_s.cmd[7:2] = s.wdata_q[7:2]; // RULE_21
                `WDAC_OFS_WD_LO:
                    next_s.reload[7:0] = s.wdata_q; // RULE_01
                `WDAC_OFS_WD_HI:
                    next_s.reload[15:8] = s.wdata_q; // RULE_01
                `WDAC_OFS_ALM_MIN:
                    next_s.alm_min = s.wdata_q;
                `WDAC_OFS_ALM_HR:
                    next_s.alm_hr = s.wdata_q;
                `WDAC_OFS_ALM_DAY:
                    next_s.alm_day = s.wdata_q & ~`WDAC_DAY_RO;
                default:
                    next_s.cmd = s.cmd;
            endcase
        end
        if (wd_touch)
            next_s.count = next_s.reload; // RULE_02
        else if (wd_expire)
            next_s.count = s.reload; // RULE_04
        else if (tick && s.reload != 16'h0000)
            next_s.count = bcd_dec(s.count); // RULE_22
        // set wins over clear; pulse mode drops flag with the pulse
        next_s.wd_flag = wd_expire || (s.wd_flag && !wd_touch &&
            (!s.cmd[`WDAC_CMD_PULSE] || p_active[0])); // RULE_16 RULE_18
        next_s.al_flag = al_event || (s.al_flag && !al_touch &&
            (!s.cmd[`WDAC_CMD_PULSE] || p_active[1])); // RULE_17 RULE_18
        next_s.cmd[`WDAC_CMD_WDFLAG] = next_s.wd_flag;
        next_s.cmd[`WDAC_CMD_ALFLAG] = next_s.al_flag;
        next_s.rd_oe = (phase_now == wdac_pkg::BUS_READ) && is_mine(addr_in);
        case (addr_in)
            `WDAC_OFS_CMD: next_s.rdata = s.cmd;
            `WDAC_OFS_WD_LO: next_s.rdata = s.reload[7:0]; // RULE_05
            `WDAC_OFS_WD_HI: next_s.rdata = s.reload[15:8]; // RULE_05
            `WDAC_OFS_ALM_MIN: next_s.rdata = s.alm_min;
            `WDAC_OFS_ALM_HR: next_s.rdata = s.alm_hr;
            `WDAC_OFS_ALM_DAY: next_s.rdata = s.alm_day;
            default: next_s.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            s <= '0;
            s.cmd <= `WDAC_CMD_RESET;
            s.reload <= `WDAC_RELOAD_RESET;
            s.count <= `WDAC_RELOAD_RESET;
            s.phase <= wdac_pkg::BUS_IDLE;
        end
        else
            s <= next_s;
    end

    assign dq_out = s.rdata;
    assign dq_oe_out = s.rd_oe;
    assign transfer_strobe_out =
        tick && s.cmd[`WDAC_CMD_XFER]; // RULE_09 RULE_19

    // level mode follows flag, pulse mode follows stretcher
    assign wd_act = !s.cmd[`WDAC_CMD_WDMASK] &&
        (s.cmd[`WDAC_CMD_PULSE] ? p_active[0] : s.wd_flag); // RULE_13 RULE_14
    assign al_act = !s.cmd[`WDAC_CMD_ALMASK] &&
        (s.cmd[`WDAC_CMD_PULSE] ? p_active[1] : s.al_flag); // RULE_13 RULE_15

    // first pin always sinks; second sinks or sources per polarity
    assign first_interrupt_pin_out = 1'b0;
    assign first_interrupt_pin_oe_out =
        s.cmd[`WDAC_CMD_SWAP] ? al_act : wd_act; // RULE_10
    assign second_interrupt_pin_out = s.cmd[`WDAC_CMD_POL]; // RULE_12
    assign second_interrupt_pin_oe_out =
        s.cmd[`WDAC_CMD_SWAP] ? wd_act : al_act; // RULE_10

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_restart;
        wd_touch |=> s.count == s.reload && s.wd_flag == $past(wd_expire);
    endproperty
    a_restart: assert property (p_restart) // RULE_02
        else $error("reload access did not restart countdown");

    property p_expire_reload;
        wd_expire |=> s.count == s.reload && s.wd_flag;
    endproperty
    a_expire_reload: assert property (p_expire_reload) // RULE_04
        else $error("expiry did not reload count and set flag");

    property p_disabled;
        s.reload == 16'h0000 && !s.wd_flag |=> !s.wd_flag;
    endproperty
    a_disabled: assert property (p_disabled) // RULE_06
        else $error("watchdog expired while disabled");

    property p_readback;
        phase_now == wdac_pkg::BUS_READ && addr_in == `WDAC_OFS_WD_LO
            |=> dq_oe_out && dq_out == $past(s.reload[7:0]);
    endproperty
    a_readback: assert property (p_readback) // RULE_05
        else $error("reload read did not return entered value");

    property p_ro_flags;
        wr_end && s.addr_q == `WDAC_OFS_CMD
            |=> s.cmd[7:2] == $past(s.wdata_q[7:2]) &&
                s.cmd[1:0] == {s.wd_flag, s.al_flag};
    endproperty
    a_ro_flags: assert property (p_ro_flags) // RULE_21
        else $error("command write wrong or flags overwritten");

    property p_wd_mask;
        s.cmd[`WDAC_CMD_WDMASK] && s.cmd[`WDAC_CMD_SWAP]
            |-> !second_interrupt_pin_oe_out;
    endproperty
    a_wd_mask: assert property (p_wd_mask) // RULE_14
        else $error("masked watchdog drove its pin");

    property p_al_mask;
        s.cmd[`WDAC_CMD_ALMASK] && s.cmd[`WDAC_CMD_SWAP]
            |-> !first_interrupt_pin_oe_out;
    endproperty
    a_al_mask: assert property (p_al_mask) // RULE_15
        else $error("masked alarm drove its pin");

    property p_pulse_flag;
        s.cmd[`WDAC_CMD_PULSE] && !p_active[0] && !wd_expire
            |=> !s.wd_flag;
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) // RULE_18
        else $error("pulse-mode flag outlived its pulse");

    property p_alarm_set;
        al_event |=> s.al_flag ##1 (s.al_flag || $past(al_touch));
    endproperty
    a_alarm_set: assert property (p_alarm_set) // RULE_17
        else $error("alarm event did not hold flag");

    property p_freeze;
        !s.cmd[`WDAC_CMD_XFER] |-> !transfer_strobe_out;
    endproperty
    a_freeze: assert property (p_freeze) // RULE_09
        else $error("transfer while frozen");

    property p_count_hold;
        s.reload == 16'h0000 && !wd_touch |=> s.count == $past(s.count);
    endproperty
    a_count_hold: assert property (p_count_hold) // RULE_22
        else $error("countdown moved while disabled");

    property p_route;
        !s.cmd[`WDAC_CMD_SWAP] && !s.cmd[`WDAC_CMD_PULSE] &&
            !s.cmd[`WDAC_CMD_WDMASK]
            |-> first_interrupt_pin_oe_out == s.wd_flag;
    endproperty
    a_route: assert property (p_route) // RULE_10
        else $error("watchdog not routed to first pin");

    c_expire: cover property (wd_expire);
    c_alarm: cover property (al_event ##1 al_touch);
    c_pulse: cover property (s.cmd[`WDAC_CMD_PULSE] && p_active[0]);
endmodule // wdac_top
`default_nettype wire

/* File: tb/tb_wdac_top.sv */
// self-checking bench for the watchdog, alarm and interrupt block
// assumes short tick and pulse counts set through parameters
`timescale 1ns/1ns
`default_nettype none
module tb_wdac_top;
    localparam int TICK = 10;
    localparam int PULSE = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr;
    logic ce_n, oe_n, we_n;
    logic [7:0] dq_w, dq_r;
    logic dq_oe, strobe, p1, p2, p1_lvl, p2_lvl;
    logic [7:0] cur_min = 8'h00;
    logic [7:0] cur_hr = 8'h00;
    logic [7:0] cur_day = 8'h00;
    logic roll = 1'b0;
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] d;
    logic oe;
    int n;

    always #50 mclk = ~mclk;

    wdac_host wdac_host_i (.mclk_in(mclk), .addr_out(addr),
        .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
        .dq_out(dq_w), .dq_in(dq_r), .dq_oe_in(dq_oe));

    wdac_top #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE)) wdac_top_i (
        .mclk_in(mclk), .rst_n_in(rst_n), .addr_in(addr), .ce_n_in(ce_n),
        .oe_n_in(oe_n), .we_n_in(we_n), .dq_in(dq_w), .dq_out(dq_r),
        .dq_oe_out(dq_oe), .cur_minutes_in(cur_min),
        .cur_hours_in(cur_hr), .cur_days_in(cur_day),
        .minute_rollover_in(roll), .transfer_strobe_out(strobe),
        .first_interrupt_pin_out(p1_lvl),
        .first_interrupt_pin_oe_out(p1),
        .second_interrupt_pin_out(p2_lvl),
        .second_interrupt_pin_oe_out(p2));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        wdac_host_i.rd(a, d, oe);
        check(d, exp);
        check({7'h00, oe}, 8'h01);
    endtask

    task automatic wait_irq(input logic sec, input int lim, output int c);
        c = 0;
        while (((sec ? p2 : p1) !== 1'b1) && c < lim)
        begin
            @(negedge mclk);
            c++;
        end
    endtask

    task automatic minute_roll;
        @(negedge mclk);
        roll = 1'b1;
        @(negedge mclk);
        roll = 1'b0;
        @(negedge mclk);
    endtask

    task automatic t_reset;
        rchk(4'hB, 8'h8C);
        rchk(4'hC, 8'h00);
        rchk(4'hD, 8'h00);
        wdac_host_i.rd(4'hE, d, oe);
        check({7'h00, oe}, 8'h00);
        wdac_host_i.wr(4'hB, 8'hFF);
        rchk(4'hB, 8'hFC);
    endtask

    task automatic t_transfer;
        wdac_host_i.wr(4'hB, 8'h00);
        n = 0;
        repeat (3 * TICK)
        begin
            @(negedge mclk);
            n += int'(strobe === 1'b1);
        end
        check(8'(n), 8'h00);
        wdac_host_i.wr(4'hB, 8'h80);
        n = 0;
        repeat (3 * TICK)
        begin
            @(negedge mclk);
            n += int'(strobe === 1'b1);
        end
        check(8'(n), 8'h03);
    endtask

    task automatic t_watchdog;
        wdac_host_i.wr(4'hB, 8'h40);
        wdac_host_i.wr(4'hD, 8'h00);
        wdac_host_i.wr(4'hC, 8'h03);
        wait_irq(1'b1, 60, n);
        check({7'h00, n >= 2 * TICK && n <= 3 * TICK + 4}, 8'h01);
        check({7'h00, p2_lvl}, 8'h00);
        check({7'h00, p1}, 8'h00);
        rchk(4'hB, 8'h42);
        check({7'h00, p2}, 8'h01);
        rchk(4'hC, 8'h03);
        check({7'h00, p2}, 8'h00);
        rchk(4'hB, 8'h40);
        wait_irq(1'b1, 60, n);
        check({7'h00, n >= TICK && n <= 3 * TICK + 4}, 8'h01);
    endtask

    task automatic t_pulse_mask;
        wdac_host_i.wr(4'hB, 8'h10);
        rchk(4'hD, 8'h00);
        wait_irq(1'b0, 60, n);
        check({7'h00, n < 60}, 8'h01);
        n = 0;
        while (p1 === 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        check(8'(n), 8'(PULSE));
        rchk(4'hB, 8'h10);
        wdac_host_i.wr(4'hB, 8'h08);
        wdac_host_i.rd(4'hC, d, oe);
        wait_irq(1'b0, 50, n);
        check(8'(n), 8'h32);
        rchk(4'hB, 8'h0A);
        wdac_host_i.wr(4'hC, 8'h00);
        wdac_host_i.wr(4'hB, 8'h00);
        wait_irq(1'b0, 60, n);
        check(8'(n), 8'h3C);
        rchk(4'hB, 8'h00);
    endtask

    task automatic t_alarm;
        wdac_host_i.wr(4'hB, 8'h60);
        check({7'h00, p2_lvl}, 8'h01);
        cur_min = 8'h30;
        wdac_host_i.wr(4'h3, 8'h30);
        wdac_host_i.wr(4'h5, 8'h80);
        wdac_host_i.wr(4'h7, 8'hF8);
        rchk(4'h7, 8'h80);
        minute_roll();
        check({7'h00, p1}, 8'h01);
        check({7'h00, p1_lvl}, 8'h00);
        rchk(4'hB, 8'h61);
        rchk(4'h3, 8'h30);
        check({7'h00, p1}, 8'h00);
        cur_min = 8'h31;
        minute_roll();
        check({7'h00, p1}, 8'h00);
        wdac_host_i.wr(4'h3, 8'hB0);
        minute_roll();
        check({7'h00, p1}, 8'h01);
        wdac_host_i.wr(4'hB, 8'h64);
        wdac_host_i.rd(4'h3, d, oe);
        minute_roll();
        check({7'h00, p1}, 8'h00);
        rchk(4'hB, 8'h65);
        wdac_host_i.wr(4'hB, 8'h60);
        wdac_host_i.wr(4'h3, 8'h31);
        wdac_host_i.wr(4'h5, 8'h05);
        minute_roll();
        check({7'h00, p1}, 8'h00);
        cur_hr = 8'h05;
        minute_roll();
        check({7'h00, p1}, 8'h01);
        wdac_host_i.wr(4'h7, 8'h02);
        minute_roll();
        check({7'h00, p1}, 8'h00);
        cur_day = 8'h02;
        minute_roll();
        check({7'h00, p1}, 8'h01);
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && total_checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial
    begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_transfer();
        t_watchdog();
        t_pulse_mask();
        t_alarm();
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
endmodule // tb_wdac_top
`default_nettype wire

/* File: tb/wdac_host.sv */
// host processor model: byte-wide asynchronous bus master
// assumes inputs of the block are sampled on its rising clock edge
`timescale 1ns/1ns
`default_nettype none
module wdac_host (
    input wire logic mclk_in,
    output logic [3:0] addr_out,
    output logic ce_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [7:0] dq_out,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe_in
);
    initial
    begin
        addr_out = 4'h0;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        we_n_out = 1'b1;
        dq_out = 8'h00;
    end
    // only the four mask patterns are ever programmed
    // no square wave is enabled by this host
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        addr_out = a;
        dq_out = d;
        ce_n_out = 1'b0;
        we_n_out = 1'b0;
        @(negedge mclk_in);
        ce_n_out = 1'b1;
        we_n_out = 1'b1;
        @(negedge mclk_in);
        // released data no longer shows the last value
        dq_out = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d,
        output logic oe);
        @(negedge mclk_in);
        addr_out = a;
        ce_n_out = 1'b0;
        oe_n_out = 1'b0;
        @(negedge mclk_in);
        d = dq_in;
        oe = dq_oe_in;
        ce_n_out = 1'b1;
        oe_n_out = 1'b1;
        @(negedge mclk_in);
    endtask
endmodule // wdac_host
`default_nettype wire
